/* File: hw/nv_ctrl.sv */
// Our own choice: the Avalon-MM interface to the registers.
`include "nested_vector_irq_ctrl_map.svh"
`default_nettype none
module nv_ctrl
	import nv_pkg::*;
#(
	parameter int NUM_IRQ = `NV_NUM_IRQ // [R18]
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic srst,
	// Avalon-MM slave.
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_privileged,
	output logic [31:0] avs_readdata,
	output logic [1:0] avs_response,
	output logic avs_waitrequest,
	// Peripheral request lines.
	input wire logic [NUM_IRQ-1:0] irq_lines,
	// Processor core side.
	output logic core_irq_req,
	output logic [6:0] core_irq_num,
	output logic [3:0] core_irq_prio,
	input wire logic core_irq_enter,
	input wire logic [6:0] core_enter_num,
	input wire logic core_irq_exit,
	input wire logic [6:0] core_exit_num
);
	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	localparam int PAD = `NV_BANK_WORDS * 32;
	logic [NUM_IRQ-1:0] enable_reg, enable_next;
	logic [NUM_IRQ-1:0] pending_reg, pending_next;
	logic [NUM_IRQ-1:0] active_reg, active_next;
	logic [NUM_IRQ*4-1:0] prio_reg, prio_next;
	logic [NUM_IRQ-1:0] line_sync, line_prev_reg, line_prev_next;
	nv_bus_state_t bus_state_reg, bus_state_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] resp_reg, resp_next;
	logic found;
	logic [6:0] winner;
	nv_prio_t win_prio;
	logic req_reg, req_next;
	logic [6:0] num_reg, num_next;
	logic [3:0] prio_out_reg, prio_out_next;

	nv_sync #(
		.WIDTH(NUM_IRQ)
	) u_sync (
		.mclk(mclk),
		.srst(srst),
		.d(irq_lines),
		.q(line_sync)
	);

	nv_arbiter #(
		.NUM_IRQ(NUM_IRQ)
	) u_arb (
		.cand(pending_reg & enable_reg & ~active_reg), // [R03] [R04]
		.prio(prio_reg),
		.found(found),
		.winner(winner),
		.win_prio(win_prio)
	);

	// ----------------------------------------------------------------
	// Address decode helpers.
	// ----------------------------------------------------------------
	function automatic logic in_bank(input logic [9:0] a, input logic [9:0] base);
		in_bank = (a >= base) && (a < base + 10'(`NV_BANK_WORDS * 4));
	endfunction

	function automatic logic [1:0] word_of(input logic [9:0] a, input logic [9:0] base);
		logic [9:0] d;
		d = a - base;
		word_of = d[3:2];
	endfunction

	function automatic logic [31:0] bank_word(input logic [NUM_IRQ-1:0] v, input logic [1:0] w);
		logic [PAD-1:0] p;
		p = PAD'(v);
		bank_word = p[w*32 +: 32]; // [R22]
	endfunction

	function automatic logic [NUM_IRQ-1:0] bank_mask(input logic [31:0] d, input logic [1:0] w);
		logic [PAD-1:0] p;
		p = '0;
		p[w*32 +: 32] = d; // [R22]
		bank_mask = p[NUM_IRQ-1:0];
	endfunction

	// ----------------------------------------------------------------
	// Register access and interrupt state.
	// ----------------------------------------------------------------
	logic [9:0] a;
	logic acc;
	logic is_ier, is_icer, is_pset, is_pclr, is_iabr, is_prio, mapped;
	logic [4:0] prio_word;
	logic [9:0] prio_off;
	logic [1:0] bw;
	logic [NUM_IRQ-1:0] wmask;
	logic [NUM_IRQ-1:0] set_mask;

	always_comb begin
		a = avs_address;
		acc = (bus_state_reg == NV_BUS_IDLE) && (avs_read || avs_write);
		is_ier = in_bank(a, `NV_ISER_BASE);
		is_icer = in_bank(a, `NV_ICER_BASE);
		is_pset = in_bank(a, `NV_PSET_BASE);
		is_pclr = in_bank(a, `NV_PCLR_BASE);
		is_iabr = in_bank(a, `NV_IABR_BASE);
		prio_off = a - `NV_PRIO_BASE;
		is_prio = (a >= `NV_PRIO_BASE) && (prio_off < 10'(`NV_PRIO_WORDS * 4));
		prio_word = prio_off[6:2];
		mapped = is_ier | is_icer | is_pset | is_pclr | is_iabr | is_prio;
		bw = 2'h0;
		if (is_icer) begin
			bw = word_of(a, `NV_ICER_BASE);
		end else if (is_pset) begin
			bw = word_of(a, `NV_PSET_BASE);
		end else if (is_pclr) begin
			bw = word_of(a, `NV_PCLR_BASE);
		end else if (is_iabr) begin
			bw = word_of(a, `NV_IABR_BASE);
		end else begin
			bw = word_of(a, `NV_ISER_BASE);
		end
		wmask = bank_mask(avs_writedata, bw);

		enable_next = enable_reg;
		pending_next = pending_reg;
		active_next = active_reg;
		prio_next = prio_reg;
		line_prev_next = line_sync;
		bus_state_next = NV_BUS_IDLE;
		rdata_next = rdata_reg;
		resp_next = resp_reg;

		// Handler exit retires the active state.
		if (core_irq_exit && 32'(core_exit_num) < NUM_IRQ) begin
			active_next[core_exit_num] = 1'b0;
		end
		// Handler entry moves pending to active.
		if (core_irq_enter && 32'(core_enter_num) < NUM_IRQ) begin
			pending_next[core_enter_num] = 1'b0; // [R21]
			active_next[core_enter_num] = 1'b1; // [R21]
		end

		if (acc) begin
			bus_state_next = NV_BUS_RESP;
			rdata_next = 32'h0000_0000;
			resp_next = `NV_RESP_OK;
			if (!avs_privileged) begin
				resp_next = `NV_RESP_ERR; // [R23] [R17]
			end else if (!mapped) begin
				resp_next = `NV_RESP_DECERR;
			end else if (avs_write) begin
				if (is_ier) begin
					enable_next = enable_next | wmask; // [R01]
				end
				if (is_icer) begin
					enable_next = enable_next & ~wmask; // [R02]
				end
				if (is_pclr) begin
					pending_next = pending_next & ~wmask; // [R08] [R09]
				end
				if (is_prio) begin
					for (int k = 0; k < 4; k++) begin
						if (avs_byteenable[k] && 32'(prio_word) * 4 + k < NUM_IRQ) begin // [R11]
							prio_next[(32'(prio_word) * 4 + k) * 4 +: 4] =
								avs_writedata[k*8+4 +: 4]; // [R13] [R14] [R15]
						end
					end
				end
				// Writes to the active flags fall through unused. [R24]
			end else begin
				if (is_ier || is_icer) begin
					rdata_next = bank_word(enable_reg, bw); // [R01] [R02]
				end else if (is_pset || is_pclr) begin
					rdata_next = bank_word(pending_reg, bw); // [R05] [R08]
				end else if (is_iabr) begin
					rdata_next = bank_word(active_reg, bw); // [R10]
				end else begin
					for (int k = 0; k < 4; k++) begin
						if (32'(prio_word) * 4 + k < NUM_IRQ) begin
							rdata_next[k*8 +: 8] = {prio_reg[(32'(prio_word) * 4 + k) * 4 +: 4],
								4'h0}; // [R13] [R14] [R15]
						end
					end
				end
			end
		end

		// Hardware pending sources; set wins over any clear this cycle.
		// A held line pends only while the interrupt is not about to be active.
		set_mask = (line_sync & ~active_next) | (line_sync & ~line_prev_reg); // [R20] [R04] [R19]
		if (acc && avs_privileged && avs_write && is_pset) begin
			set_mask = set_mask | wmask; // [R05] [R06] [R07]
		end
		pending_next = pending_next | set_mask;

		req_next = found;
		num_next = found ? winner : 7'h00;
		prio_out_next = found ? win_prio : 4'h0;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			enable_reg <= '0; // [R16]
			pending_reg <= '0;
			active_reg <= '0;
			prio_reg <= '0;
			line_prev_reg <= '0;
			bus_state_reg <= NV_BUS_IDLE;
			rdata_reg <= 32'h0000_0000;
			resp_reg <= `NV_RESP_OK;
			req_reg <= 1'b0;
			num_reg <= 7'h00;
			prio_out_reg <= 4'h0;
		end else begin
			enable_reg <= enable_next;
			pending_reg <= pending_next;
			active_reg <= active_next;
			prio_reg <= prio_next;
			line_prev_reg <= line_prev_next;
			bus_state_reg <= bus_state_next;
			rdata_reg <= rdata_next;
			resp_reg <= resp_next;
			req_reg <= req_next;
			num_reg <= num_next;
			prio_out_reg <= prio_out_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs.
	// ----------------------------------------------------------------
	always_comb begin
		avs_waitrequest = (avs_read || avs_write) && (bus_state_reg != NV_BUS_RESP);
		avs_readdata = rdata_reg;
		avs_response = resp_reg;
		core_irq_req = req_reg;
		core_irq_num = num_reg;
		core_irq_prio = prio_out_reg;
	end
endmodule
`default_nettype wire

/* File: hw/nested_vector_irq_ctrl_map.svh */
// Notes on behaviour
// R01: Enable-set write one enables; read shows enables.
// R02: Enable-clear write one disables; read shows enables.
// R03: Pending and enabled interrupt activates by priority.
// R04: Disabled line still pends, never activates.
// R05: Pending-set write one pends; read shows pending.
// R06: Pending-set on pending interrupt changes nothing.
// R07: Pending-set on disabled interrupt still pends.
// R08: Pending-clear write one unpends; read shows pending.
// R09: Pending-clear leaves active state alone.
// R10: Active flags read one while active.
// R11: Eight-bit priority per interrupt, byte-accessible words.
// R12: Lower priority value wins selection.
// R13: Only upper four priority bits stored.
// R14: Interrupt N in word N/4, byte N%4.
// R15: Byte select k maps to bits 8k+7:8k.
// R16: All state resets to zero.
// R17: Software accesses only while privileged.
// R18: Up to 81 interrupt inputs.
// R19: Pulse requests last at least one clock.
// R20: Pends on high while inactive, or rising edge.
// R21: Handler entry clears pending, sets active.
// R22: Interrupt N at bit N%32 of word N/32.
// R23: Unprivileged access changes nothing, answers error.
// R24: Writes to active flags are ignored.
`ifndef NV_MAP_SVH
`define NV_MAP_SVH
`define NV_NUM_IRQ 81
`define NV_ISER_BASE 10'h000
`define NV_ICER_BASE 10'h020
`define NV_PSET_BASE 10'h040
`define NV_PCLR_BASE 10'h060
`define NV_IABR_BASE 10'h080
`define NV_PRIO_BASE 10'h100
`define NV_BANK_WORDS 3
`define NV_PRIO_WORDS 21
`define NV_PRIO_MASK 8'hf0
`define NV_RESP_OK 2'h0
`define NV_RESP_ERR 2'h2
`define NV_RESP_DECERR 2'h3
`endif

/* File: hw/nv_pkg.sv */
`default_nettype none
package nv_pkg;
	typedef enum logic [1:0] {
		NV_BUS_IDLE,
		NV_BUS_RESP
	} nv_bus_state_t;
	typedef logic [3:0] nv_prio_t;
endpackage
`default_nettype wire

/* File: hw/nv_sync.sv */
`default_nettype none
module nv_sync #(
	parameter int WIDTH = 81
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic srst,
	// Data.
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] q_next;

	always_comb begin
		meta_next = d;
		q_next = meta_reg;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= meta_next;
			q <= q_next;
		end
	end
endmodule
`default_nettype wire

/* File: hw/nv_arbiter.sv */
`default_nettype none
module nv_arbiter
	import nv_pkg::*;
#(
	parameter int NUM_IRQ = 81
) (
	// Candidates.
	input wire logic [NUM_IRQ-1:0] cand,
	input wire logic [NUM_IRQ*4-1:0] prio,
	// Winner.
	output logic found,
	output logic [6:0] winner,
	output nv_prio_t win_prio
);
	// ----------------------------------------------------------------
	// Lowest value wins; ties go to the lowest interrupt number.
	// ----------------------------------------------------------------
	always_comb begin
		found = 1'b0;
		winner = 7'h00;
		win_prio = 4'hf;
		for (int i = 0; i < NUM_IRQ; i++) begin
			if (cand[i] && (!found || prio[i*4 +: 4] < win_prio)) begin // [R12] [R03]
				found = 1'b1;
				winner = 7'(i);
				win_prio = prio[i*4 +: 4];
			end
		end
	end
endmodule
`default_nettype wire

/* File: dv/iep_ctrl_monitor.sv */
`include "nested_vector_irq_ctrl_map.svh"
`default_nettype none
module iep_ctrl_monitor #(
	parameter int NUM_IRQ = 81
) (
	// Bus.
	input wire logic mclk,
	input wire logic srst,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_privileged,
	input wire logic [31:0] avs_readdata,
	input wire logic [1:0] avs_response,
	input wire logic avs_waitrequest,
	// Core.
	input wire logic core_irq_req,
	input wire logic [6:0] core_irq_num,
	input wire logic core_irq_enter,
	input wire logic [6:0] core_enter_num
);
	timeunit 1ns;
	timeprecision 1ps;
	// ---
	// Checks.
	// ---
	wire logic rq = avs_read || avs_write;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	property p_answer;
		rq && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	property p_idle;
		rq && !avs_waitrequest |-> $past(avs_waitrequest);
	endproperty
	a_idle: assert property (p_idle) else $error("answer without wait");
	property p_nib;
		avs_read && avs_privileged && !avs_waitrequest && avs_address >= 10'h100
			&& avs_address < 10'h154 |-> (avs_readdata & 32'h0f0f_0f0f) == 32'h0;
	endproperty
	a_nib: assert property (p_nib) else $error("low priority bits set");
	property p_priv;
		rq && !avs_privileged && !avs_waitrequest |-> avs_response == `NV_RESP_ERR;
	endproperty
	a_priv: assert property (p_priv) else $error("unprivileged answer");
	property p_unmap;
		avs_read && avs_privileged && !avs_waitrequest && avs_address >= 10'h154
			|-> avs_response == `NV_RESP_DECERR && avs_readdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped answer");
	property p_hold;
		!rq |=> $stable(avs_readdata) && $stable(avs_response);
	endproperty
	a_hold: assert property (p_hold) else $error("answer moved");
	property p_rst;
		$fell(srst) |-> !core_irq_req && avs_readdata == 32'h0 && avs_response == 2'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_num;
		core_irq_req |-> core_irq_num < NUM_IRQ;
	endproperty
	a_num: assert property (p_num) else $error("number range");
	property p_enter;
		core_irq_enter && core_irq_req && core_enter_num == core_irq_num
			|-> ##2 (!core_irq_req || core_irq_num != $past(core_irq_num, 2));
	endproperty
	a_enter: assert property (p_enter) else $error("taken still requested");
endmodule
bind nv_ctrl iep_ctrl_monitor #(.NUM_IRQ(NUM_IRQ)) i_mon (.mclk, .srst, .avs_address,
	.avs_read, .avs_write, .avs_privileged, .avs_readdata, .avs_response,
	.avs_waitrequest, .core_irq_req, .core_irq_num, .core_irq_enter, .core_enter_num);
`default_nettype wire

/* File: dv/iep_far_model.sv */
`default_nettype none
module iep_far_model #(
	parameter int NUM_IRQ = 81
) (
	// Core side.
	input wire logic mclk,
	input wire logic [6:0] core_irq_num,
	output logic core_irq_enter,
	output logic [6:0] core_enter_num,
	output logic core_irq_exit,
	output logic [6:0] core_exit_num,
	// Peripheral lines.
	output logic [NUM_IRQ-1:0] irq_lines
);
	timeunit 1ns;
	timeprecision 1ps;
	// ---
	// Sources and core.
	// ---
	initial begin
		irq_lines = '0;
		core_irq_enter = 1'b0;
		core_enter_num = 7'h00;
		core_irq_exit = 1'b0;
		core_exit_num = 7'h00;
	end
	task automatic pulse(input int n);
		@(posedge mclk);
		irq_lines[n] <= 1'b1;
		@(posedge mclk);
		irq_lines[n] <= 1'b0;
	endtask
	task automatic take(input int dly);
		repeat (dly) @(posedge mclk);
		@(posedge mclk);
		core_irq_enter <= 1'b1;
		core_enter_num <= core_irq_num;
		@(posedge mclk);
		core_irq_enter <= 1'b0;
		core_enter_num <= ~core_enter_num;
	endtask
	task automatic leave(input logic [6:0] n);
		@(posedge mclk);
		core_irq_exit <= 1'b1;
		core_exit_num <= n;
		@(posedge mclk);
		core_irq_exit <= 1'b0;
		core_exit_num <= ~n;
	endtask
endmodule
`default_nettype wire

/* File: dv/irq_enable_pending_priority_tb.sv */
`default_nettype none
module irq_enable_pending_priority_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ---
	// Bench.
	// ---
	logic mclk = 1'b0;
	logic srst;
	logic [9:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic avs_privileged;
	logic [31:0] avs_readdata;
	logic [1:0] avs_response;
	logic avs_waitrequest;
	logic [80:0] irq_lines;
	logic core_irq_req;
	logic [6:0] core_irq_num;
	logic [3:0] core_irq_prio;
	logic core_irq_enter;
	logic [6:0] core_enter_num;
	logic core_irq_exit;
	logic [6:0] core_exit_num;
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	always #4 mclk = ~mclk;
	nv_ctrl i_dut (
		.mclk(mclk),
		.srst(srst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_privileged(avs_privileged),
		.avs_readdata(avs_readdata),
		.avs_response(avs_response),
		.avs_waitrequest(avs_waitrequest),
		.irq_lines(irq_lines),
		.core_irq_req(core_irq_req),
		.core_irq_num(core_irq_num),
		.core_irq_prio(core_irq_prio),
		.core_irq_enter(core_irq_enter),
		.core_enter_num(core_enter_num),
		.core_irq_exit(core_irq_exit),
		.core_exit_num(core_exit_num)
	);
	iep_far_model i_far (
		.mclk(mclk),
		.core_irq_num(core_irq_num),
		.core_irq_enter(core_irq_enter),
		.core_enter_num(core_enter_num),
		.core_irq_exit(core_irq_exit),
		.core_exit_num(core_exit_num),
		.irq_lines(irq_lines)
	);
	task automatic wrap_up;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
		input logic [3:0] be, input logic pv, output logic [31:0] r, output logic [1:0] s);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_privileged <= pv;
		do begin
			@(posedge mclk);
		end while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		s = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
		logic [31:0] r;
		logic [1:0] s;
		bus(1'b1, a, d, be, 1'b1, r, s);
		chk("wresp", {30'h0, s}, 32'h0);
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] e);
		logic [31:0] r;
		logic [1:0] s;
		bus(1'b0, a, 32'h0, 4'hf, 1'b1, r, s);
		chk("rdata", r, e);
	endtask
	task automatic wreq(input logic [6:0] n, input logic [3:0] p);
		int k;
		k = 0;
		while (core_irq_req !== 1'b1 && k < 20) begin
			@(posedge mclk);
			k++;
		end
		chk("irq_req", {31'h0, core_irq_req}, 32'h1);
		chk("irq_num", {25'h0, core_irq_num}, {25'h0, n});
		chk("irq_prio", {28'h0, core_irq_prio}, {28'h0, p});
	endtask
	task automatic t_reset;
		for (int i = 0; i < 15; i++) rd(10'(i / 3 * 32 + i % 3 * 4), 32'h0);
		for (int i = 0; i < 21; i++) rd(10'(256 + i * 4), 32'h0);
	endtask
	task automatic t_enable;
		logic [31:0] r;
		logic [1:0] s;
		wr(10'h000, 32'h8000_0001);
		wr(10'h000, 32'h0);
		rd(10'h000, 32'h8000_0001);
		wr(10'h020, 32'h1);
		rd(10'h020, 32'h8000_0000);
		wr(10'h008, 32'hffff_ffff);
		rd(10'h008, 32'h0001_ffff);
		wr(10'h028, 32'hffff_ffff);
		wr(10'h020, 32'h8000_0000);
		bus(1'b1, 10'h000, 32'hffff_ffff, 4'hf, 1'b0, r, s);
		chk("unpriv", {30'h0, s}, 32'h2);
		rd(10'h000, 32'h0);
		bus(1'b0, 10'h200, 32'h0, 4'hf, 1'b1, r, s);
		chk("unmap", {s, r[29:0]}, 32'hc000_0000);
	endtask
	task automatic t_pend;
		wr(10'h040, 32'h5);
		wr(10'h040, 32'h1);
		rd(10'h040, 32'h5);
		rd(10'h060, 32'h5);
		chk("no_req", {31'h0, core_irq_req}, 32'h0);
		wr(10'h060, 32'h4);
		rd(10'h060, 32'h1);
		wr(10'h060, 32'h1);
	endtask
	task automatic t_prio;
		logic [31:0] r;
		logic [1:0] s;
		wr(10'h104, 32'h1234_5678, 4'h5);
		rd(10'h104, 32'h0030_0070);
		wr(10'h000, 32'h50);
		wr(10'h040, 32'h50);
		wreq(7'h06, 4'h3);
		i_far.take(0);
		rd(10'h080, 32'h40);
		rd(10'h040, 32'h10);
		wreq(7'h04, 4'h7);
		wr(10'h040, 32'h40);
		wr(10'h060, 32'h50);
		bus(1'b1, 10'h080, 32'hffff_ffff, 4'hf, 1'b1, r, s);
		rd(10'h080, 32'h40);
		chk("no_req", {31'h0, core_irq_req}, 32'h0);
		i_far.leave(7'h06);
		rd(10'h080, 32'h0);
		wr(10'h020, 32'h50);
	endtask
	task automatic t_line;
		wr(10'h008, 32'h40);
		i_far.pulse(70);
		i_far.pulse(71);
		wreq(7'h46, 4'h0);
		rd(10'h048, 32'hc0);
		i_far.take(3);
		rd(10'h048, 32'h80);
		i_far.pulse(70);
		repeat (2) @(posedge mclk);
		rd(10'h048, 32'hc0);
		rd(10'h088, 32'h40);
		i_far.leave(7'h46);
		wreq(7'h46, 4'h0);
		i_far.take(1);
		i_far.leave(7'h46);
		wr(10'h068, 32'h80);
		wr(10'h028, 32'h40);
		rd(10'h048, 32'h0);
	endtask
	initial begin
		srst <= 1'b1;
		avs_address <= 10'h000;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= 32'h0;
		avs_byteenable <= 4'h0;
		avs_privileged <= 1'b0;
		repeat (5) @(posedge mclk);
		srst <= 1'b0;
		t_reset();
		t_enable();
		t_pend();
		t_prio();
		t_line();
		wrap_up();
	end
endmodule
`default_nettype wire
